// ==== boot_strap_sampler.sv ====
// Purpose: Captures board straps after power-on reset into configuration
// Assumes: 10 MHz CLOCK; power-on reset pin asynchronous to CLOCK
// Notes: Debug drive of strap pins allowed only after capture
`timescale 1ns/100ps
module boot_strap_sampler
  import strap_pkg::*;
#(
  parameter int CAPTURE_CNT = CAPTURE_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic POWER_ON_RESET_N,
  input wire logic PARK_REQUEST_N,
  input wire logic [N_STRAPS-1:0] STRAP_IN,
  output logic [N_STRAPS-1:0] STRAP_OUT,
  output logic [N_STRAPS-1:0] STRAP_OE,
  input wire logic [N_STRAPS-1:0] DEBUG_OUT,
  input wire logic DEBUG_EN,
  input wire logic MONITOR_INTEGRITY_FLASH,
  output logic STRAPS_VALID,
  output logic DEVICE_RESET,
  output logic PARK_ARRAY,
  output logic HOST_USES_I2C,
  output logic HOST_USES_SPI,
  output logic MONITOR_USES_I2C,
  output logic MONITOR_USES_SPI,
  output logic SPI_PHASE_SEL,
  output logic HOST_INTEGRITY_SEL,
  output logic MONITOR_INTEGRITY_SEL
);
  localparam int SW = N_STRAPS + 2;
  localparam int POR_BIT = N_STRAPS;
  localparam int PARK_BIT = N_STRAPS + 1;
  // Reset state: in reset, park requested, straps low
  localparam logic [SW-1:0] SYNC_INIT = '0;

  strap_if #(.W(SW)) sync_bus ();

  pin_sync #(.W(SW), .INIT(SYNC_INIT)) u_sync (
    .clock(CLOCK),
    .reset(RESET),
    .clk_en(CLK_EN),
    .pins({PARK_REQUEST_N, POWER_ON_RESET_N, STRAP_IN}),
    .out(sync_bus)
  );

  wire por_n = sync_bus.level[POR_BIT];
  wire park_n = sync_bus.level[PARK_BIT];
  wire [N_STRAPS-1:0] strap_lvl = sync_bus.level[N_STRAPS-1:0];

  boot_state_e state_r;
  boot_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [N_STRAPS-1:0] cap_r;
  logic [N_STRAPS-1:0] cap_nxt;
  logic park_r;
  logic [N_STRAPS-1:0] dout_r;
  logic [N_STRAPS-1:0] doe_r;
  logic flash_r;
  logic [CNT_W-1:0] wait_len_r;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CAPTURE_CNT - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(CAPTURE_CNT);

  wire cnt_done = (cnt_r == CNT_LAST);
  wire capture_now = (state_r == ST_WAIT) && cnt_done && por_n;
  wire captured = (state_r == ST_DONE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cap_nxt = cap_r;
    case (state_r)
      ST_RESET: begin
        cnt_nxt = '0;
        if (por_n) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!por_n) begin
          state_nxt = ST_RESET;
        end else if (cnt_done) begin
          cap_nxt = strap_lvl;
          state_nxt = ST_DONE;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      ST_DONE: begin
        // Pins ignored here; only a new reset reopens capture
        if (!por_n) begin
          state_nxt = ST_RESET;
        end
      end
      default: state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_r <= ST_RESET;
      cnt_r <= '0;
      cap_r <= '0;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
    end
  end

  // Park follows pin on every enabled cycle in any state, and is forced while in reset
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      park_r <= 1'h1;
    end else if (CLK_EN) begin
      park_r <= (park_n == PARK_ASSERTED) || !por_n;
    end
  end

  // Debug drive only once captured and never during reset
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      doe_r <= '0;
      dout_r <= '0;
    end else if (CLK_EN) begin
      doe_r <= (captured && por_n && DEBUG_EN) ? '1 : '0;
      dout_r <= DEBUG_OUT;
    end
  end

  // Flash choice is registered so the monitor setting is a clean level
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      flash_r <= INTEGRITY_CRC8;
    end else if (CLK_EN) begin
      flash_r <= MONITOR_INTEGRITY_FLASH;
    end
  end

  // Separate count of enabled cycles spent waiting, read by the checks
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      wait_len_r <= '0;
    end else if (CLK_EN) begin
      if (state_r == ST_WAIT) begin
        wait_len_r <= wait_len_r + CNT_W'(1);
      end else begin
        wait_len_r <= '0;
      end
    end
  end

  // Raw pin gates the enable so the pads float at once when reset falls,
  // not four or five cycles later, one edge after the filtered level catches up
  assign STRAP_OE = POWER_ON_RESET_N ? doe_r : '0;
  assign STRAP_OUT = dout_r;
  assign STRAPS_VALID = captured;
  assign DEVICE_RESET = !captured;
  assign PARK_ARRAY = park_r;

  function automatic logic is_i2c(input logic sel);
    return sel == HOST_PORT_I2C;
  endfunction

  // Open straps read 0 through the pad pull-downs, matching reset values
  wire host_i2c = is_i2c(cap_r[STRAP_HOST_SEL]);
  assign HOST_USES_I2C = host_i2c;
  assign HOST_USES_SPI = !host_i2c;
  assign MONITOR_USES_I2C = !host_i2c;
  assign MONITOR_USES_SPI = host_i2c;
  assign SPI_PHASE_SEL = cap_r[STRAP_SPI_MODE];
  assign HOST_INTEGRITY_SEL = cap_r[STRAP_INTEGRITY];
  assign MONITOR_INTEGRITY_SEL = flash_r;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence s_release;
    (state_r == ST_RESET) && por_n && CLK_EN;
  endsequence

  a_no_drive_reset: assert property (
    !por_n |=> (STRAP_OE == '0))
    else $error("strap pin driven during power-on reset");
  a_drive_after_cap: assert property (
    (STRAP_OE != '0) |-> $past(captured))
    else $error("strap pin driven before capture");
  a_capture_time: assert property (
    s_release ##1 (CLK_EN && por_n) [*2] |-> !captured)
    else $error("straps captured too early");
  a_park_follow: assert property (
    (CLK_EN && !park_n) |=> PARK_ARRAY)
    else $error("park request not honoured");
  a_hold_captured: assert property (
    (captured && $past(captured)) |-> $stable(cap_r))
    else $error("captured straps changed");
  a_port_split: assert property (
    HOST_USES_I2C != MONITOR_USES_I2C)
    else $error("host and monitor share a port");
  a_host_select: assert property (
    capture_now && CLK_EN |=>
      HOST_USES_I2C == $past(strap_lvl[STRAP_HOST_SEL]))
    else $error("host port select mismatch");
  a_reset_held: assert property (
    (CLK_EN && !por_n) |=> DEVICE_RESET)
    else $error("device left reset while reset low");
  a_integrity: assert property (
    capture_now && CLK_EN |=>
      HOST_INTEGRITY_SEL == $past(strap_lvl[STRAP_INTEGRITY]))
    else $error("integrity select mismatch");

  // Several-step behaviours are built from these
  sequence s_capture;
    capture_now && CLK_EN;
  endsequence

  sequence s_por_low;
    CLK_EN && !por_n;
  endsequence

  sequence s_drive_req;
    captured && por_n && DEBUG_EN && CLK_EN;
  endsequence

  sequence s_settled;
    captured ##1 captured;
  endsequence

  // Raw pin, not the filtered copy: the pads must float at once
  a_float_por_pin: assert property (
    !POWER_ON_RESET_N |-> (STRAP_OE == '0))
    else $error("strap pin driven while reset pin low");

  // Separate cycle count, so a wrong terminal value is caught
  a_capture_delay: assert property (
    $rose(captured) |-> (wait_len_r == CNT_FULL))
    else $error("capture delay differs from setting");

  a_wait_entry: assert property (
    s_release |=> (state_r == ST_WAIT))
    else $error("reset release did not start the wait");

  a_enter_reset: assert property (
    s_por_low |=> (state_r == ST_RESET))
    else $error("reset pin low did not reopen capture");

  a_park_in_reset: assert property (
    s_por_low |=> PARK_ARRAY)
    else $error("array not parked while in reset");

  a_unpark_follow: assert property (
    (CLK_EN && park_n && por_n) |=> !PARK_ARRAY)
    else $error("array parked without request");

  a_spi_phase: assert property (
    s_capture |=>
      SPI_PHASE_SEL == $past(strap_lvl[STRAP_SPI_MODE]))
    else $error("spi phase select mismatch");

  a_monitor_port: assert property (
    s_capture |=>
      MONITOR_USES_SPI == is_i2c($past(strap_lvl[STRAP_HOST_SEL])))
    else $error("monitor port select mismatch");

  a_hold_config: assert property (
    s_settled |-> $stable(HOST_USES_I2C) && $stable(SPI_PHASE_SEL) &&
      $stable(HOST_INTEGRITY_SEL))
    else $error("captured configuration moved");

  a_debug_drive: assert property (
    s_drive_req |=> (STRAP_OE == '1) || !POWER_ON_RESET_N)
    else $error("debug drive not granted after capture");

  a_debug_data: assert property (
    CLK_EN |=> (STRAP_OUT == $past(DEBUG_OUT)))
    else $error("debug data not forwarded");

  a_monitor_flash: assert property (
    CLK_EN |=>
      (MONITOR_INTEGRITY_SEL == $past(MONITOR_INTEGRITY_FLASH)))
    else $error("monitor integrity not from flash");

  // Clock enable low must freeze every register of the sequencer
  a_freeze_state: assert property (
    !CLK_EN |=> $stable(state_r) && $stable(cnt_r) && $stable(cap_r) &&
      $stable(park_r) && $stable(doe_r))
    else $error("state moved with clock enable low");
endmodule

// ==== strap_pkg.sv ====
// Purpose: Shared constants for the boot strap sampler
// Assumes: 10 MHz core clock
// Notes: Strap encodings and capture timing
package strap_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CAPTURE_DELAY_NS = 1500;
  // Least time rounds up to whole cycles, never below one
  localparam int CAPTURE_CYCLES_RAW =
    (CAPTURE_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CAPTURE_CYCLES =
    (CAPTURE_CYCLES_RAW < 1) ? 1 : CAPTURE_CYCLES_RAW;
  localparam int CNT_W = 8;
  localparam logic HOST_PORT_SPI = 1'h0;
  localparam logic HOST_PORT_I2C = 1'h1;
  localparam logic SPI_PHASE_MODE03 = 1'h0;
  localparam logic SPI_PHASE_MODE12 = 1'h1;
  localparam logic INTEGRITY_CRC8 = 1'h0;
  localparam logic INTEGRITY_SUM8 = 1'h1;
  localparam logic PARK_ASSERTED = 1'h0;
  localparam int N_STRAPS = 3;
  localparam int STRAP_HOST_SEL = 0;
  localparam int STRAP_SPI_MODE = 1;
  localparam int STRAP_INTEGRITY = 2;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } boot_state_e;
endpackage

// ==== strap_if.sv ====
// Purpose: Carries synchronised pin levels between sampler modules
// Assumes: Single clock domain
// Notes: Filled by the synchroniser, read by the top
`timescale 1ns/100ps
interface strap_if #(parameter int W = 4);
  logic [W-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface

// ==== pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pins
// Assumes: Inputs asynchronous to CLOCK
// Notes: Output changes only when stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [W-1:0] pins,
  strap_if.src out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;
  // First stage feeds only the second stage
  assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
  assign out.level = lvl_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      lvl_r <= INIT;
    end else if (clk_en) begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end
endmodule

// ==== strap_board.sv ====
// Purpose: Board straps and management controller beside the sampler
// Assumes: Strap pads resolve from device drive and board resistors
// Notes: Pull-down wins on open straps; fitted pull-ups give a 1
`timescale 1ns/100ps
module strap_board (
  input wire logic [2:0] oe,
  input wire logic [2:0] dout,
  input wire logic [2:0] pull_up,
  input wire logic power_fail,
  output logic [2:0] pad,
  output logic park_n
);
  // Undriven pad falls to its resistor, never to the last value
  assign pad = (oe & dout) | (~oe & pull_up);
  // Imminent power loss drives the park request low
  assign park_n = ~power_fail;
endmodule

// ==== boot_strap_sampler_tb.sv ====
// Purpose: Boot capture, config decode, debug drive and park checks
// Assumes: Short capture count of 2 cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/100ps
module boot_strap_sampler_tb;
  import strap_pkg::*;
  localparam int CAP_TB = 2;
  logic clock, reset, por_n, pfail, dbg_en, flash, clk_en;
  logic [2:0] pulls, dbg, pad, s_out, s_oe;
  logic park_n, valid, dev_rst, park, h_i2c, h_spi, m_i2c, m_spi;
  logic phase, h_int, m_int;
  int num_errors = 0;
  int n_compared = 0;
  strap_board board (.oe(s_oe), .dout(s_out), .pull_up(pulls),
    .power_fail(pfail), .pad(pad), .park_n(park_n));
  boot_strap_sampler #(.CAPTURE_CNT(CAP_TB)) dut (.CLOCK(clock),
    .RESET(reset), .CLK_EN(clk_en), .POWER_ON_RESET_N(por_n),
    .PARK_REQUEST_N(park_n), .STRAP_IN(pad), .STRAP_OUT(s_out),
    .STRAP_OE(s_oe), .DEBUG_OUT(dbg), .DEBUG_EN(dbg_en),
    .MONITOR_INTEGRITY_FLASH(flash), .STRAPS_VALID(valid),
    .DEVICE_RESET(dev_rst), .PARK_ARRAY(park), .HOST_USES_I2C(h_i2c),
    .HOST_USES_SPI(h_spi), .MONITOR_USES_I2C(m_i2c),
    .MONITOR_USES_SPI(m_spi), .SPI_PHASE_SEL(phase),
    .HOST_INTEGRITY_SEL(h_int), .MONITOR_INTEGRITY_SEL(m_int));
  task check(input logic [2:0] seen, input logic [2:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task boot(input logic [2:0] s);
    int n;
    por_n = 0;
    pulls = s;
    flash = ~s[2];
    dbg_en = 1;
    dbg = ~s;
    @(negedge clock);
    check(s_oe, 3'h0);
    repeat (4) @(negedge clock);
    check(s_oe, 3'h0);
    check({2'h0, dev_rst}, 3'h1);
    check({2'h0, park}, 3'h1);
    por_n = 1;
    repeat (3) @(negedge clock);
    check({2'h0, valid}, 3'h0);
    n = 0;
    while (valid !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check({2'h0, valid}, 3'h1);
    // Four filter edges, one to enter the wait, then the count
    check({2'h0, n == CAP_TB + 2}, 3'h1);
    check({2'h0, dev_rst}, 3'h0);
    repeat (8) @(negedge clock);
    // Pads now carry the inverted debug pattern; config must not move
    check(s_oe, 3'h7);
    check(s_out, ~s);
    check({2'h0, h_i2c}, {2'h0, s[0]});
    check({2'h0, h_spi}, {2'h0, ~s[0]});
    check({2'h0, m_i2c}, {2'h0, ~s[0]});
    check({2'h0, m_spi}, {2'h0, s[0]});
    check({2'h0, phase}, {2'h0, s[1]});
    check({2'h0, h_int}, {2'h0, s[2]});
    check({2'h0, m_int}, {2'h0, ~s[2]});
    $display("boot with straps %h done", s);
  endtask
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end
  initial begin
    reset = 1;
    clk_en = 1;
    por_n = 0;
    pfail = 0;
    dbg_en = 0;
    flash = 0;
    pulls = 3'h0;
    dbg = 3'h0;
    repeat (8) @(negedge clock);
    reset = 0;
    for (int i = 0; i < 8; i++) begin
      boot(i[2:0]);
    end
    pfail = 1;
    repeat (8) @(negedge clock);
    check({2'h0, park}, 3'h1);
    pfail = 0;
    repeat (8) @(negedge clock);
    check({2'h0, park}, 3'h0);
    $display("park test done");
    // Enable low: the request must wait until the clock enable returns
    clk_en = 0;
    pfail = 1;
    repeat (8) @(negedge clock);
    check({2'h0, park}, 3'h0);
    check({2'h0, valid}, 3'h1);
    clk_en = 1;
    repeat (8) @(negedge clock);
    check({2'h0, park}, 3'h1);
    pfail = 0;
    $display("clock enable test done");
    finish_test();
  end
endmodule
